/* hdl/mecw_regs.svh */
// Register offsets, field positions, reset values and keys of the matrix configuration bank
`ifndef MECW_REGS_SVH
`define MECW_REGS_SVH

// ****************************************************************
// Register addresses
// ****************************************************************
`define MECW_REMAP_ADDR       32'h0FFFDF00
`define MECW_CSA_ADDR         32'hFFFFDF20
`define MECW_WPMODE_ADDR      32'h0FFFDFE4
`define MECW_WPSTAT_ADDR      32'h0FFFDFE8
`define MECW_IRQ_STAT_ADDR    32'hFFFFDF40
`define MECW_IRQ_MASK_ADDR    32'hFFFFDF44

// ****************************************************************
// Field positions
// ****************************************************************
`define MECW_CSA_CS1_BIT      1
`define MECW_CSA_CS3_BIT      3
`define MECW_CSA_PU_BIT       8
`define MECW_CSA_PD_BIT       9
`define MECW_CSA_DRIVE_BIT    17
`define MECW_CSA_NAND_BIT     24
`define MECW_CSA_MP_BIT       25
`define MECW_WP_EN_BIT        0
`define MECW_WP_KEY_LSB       8
`define MECW_WP_KEY_MSB       31
`define MECW_WS_SRC_LSB       8
`define MECW_WS_SRC_MSB       23

// ****************************************************************
// Reset values and keys
// ****************************************************************
`define MECW_CSA_RESET        32'h00000200
`define MECW_WP_PASSWORD      24'h4D4154
`define MECW_IRQ_VIOL_BIT     0
`define MECW_IRQ_MISUSE_BIT   1
`define MECW_IRQ_W            2

`endif

/* hdl/mecw_pkg.sv */
// Types shared by the matrix configuration bank and its bus routing module
package mecw_pkg;

    // Decoded external bus configuration
    typedef struct packed {
        logic cs1_controller_select;
        logic cs3_nand_logic_enable;
        logic databus_pullup_disable;
        logic databus_pulldown_disable;
        logic pad_drive_high;
        logic nand_upper_lane_select;
        logic ddr_multiport_enable;
    } mecw_csa_t;

    // Pad controls of the external data bus
    typedef struct packed {
        logic [31:0] pullup_en;
        logic [31:0] pulldown_en;
        logic        drive_high;
    } mecw_pad_t;

endpackage

/* hdl/mecw_route.sv */
// External bus chip select routing and pad control from the chip select assignment word
`timescale 1ns/1ps
module mecw_route #(
    parameter int NUM_CS    = 6,
    parameter int ADDR_W    = 26,
    parameter int DATA_W    = 32,
    parameter int NAND_W    = 16
) (
    // Clock and reset
    input  wire logic                      clk,
    input  wire logic                      rst,
    // Configuration
    input  wire mecw_pkg::mecw_csa_t       csa,
    // Memory controller side
    input  wire logic [NUM_CS-1:0]         static_memory_ctrl_cs_n,
    input  wire logic [ADDR_W-1:0]         static_memory_ctrl_addr,
    input  wire logic                      ddr_cs_n,
    input  wire logic [NAND_W-1:0]         nand_dout,
    // Pin side
    output logic [NUM_CS-1:0]              external_chip_selects_n,
    output logic [ADDR_W-1:0]              ebi_addr,
    output logic                           nand_cs_n,
    output logic [DATA_W-1:0]              nand_lane_dout,
    output mecw_pkg::mecw_pad_t            pad
);
    import mecw_pkg::*;

    logic [DATA_W-1:0] lane_d;

    always_comb
    begin
        lane_d = '0;
        if (csa.nand_upper_lane_select)                                              // R7
            lane_d[DATA_W-1 -: NAND_W] = nand_dout;
        else
            lane_d[NAND_W-1:0] = nand_dout;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            external_chip_selects_n <= '1;
            ebi_addr                <= '0;
            nand_cs_n               <= 1'b1;
            nand_lane_dout          <= '0;
        end
        else
        begin
            external_chip_selects_n <= static_memory_ctrl_cs_n;                       // R15
            if (csa.cs1_controller_select)
                external_chip_selects_n[1] <= ddr_cs_n;                               // R2
            nand_cs_n      <= csa.cs3_nand_logic_enable ? static_memory_ctrl_cs_n[3] : 1'b1;  // R3
            ebi_addr       <= static_memory_ctrl_addr;                                // R15
            nand_lane_dout <= lane_d;
        end
    end

    // Only data bits 0 to 15 carry the keepers
    genvar i;
    generate
        for (i = 0; i < 32; i++)
        begin : g_pad
            if (i < 16)
            begin : g_low
                assign pad.pullup_en[i]   = ~csa.databus_pullup_disable;              // R4
                assign pad.pulldown_en[i] = ~csa.databus_pulldown_disable;            // R5
            end
            else
            begin : g_high
                assign pad.pullup_en[i]   = 1'b0;
                assign pad.pulldown_en[i] = 1'b0;
            end
        end
    endgenerate

    assign pad.drive_high = csa.pad_drive_high;                                       // R6

    chk_cs1_ddr_route: assert property (@(posedge clk) disable iff (rst)              // R2
        csa.cs1_controller_select |=> external_chip_selects_n[1] == $past(ddr_cs_n))
        else $error("cs1 not routed from ddr controller");
    chk_cs3_nand_off: assert property (@(posedge clk) disable iff (rst)               // R3
        !csa.cs3_nand_logic_enable |=> nand_cs_n)
        else $error("nand select active while nand logic off");
endmodule

/* hdl/mecw_top.sv */
// Matrix configuration bank: remap, chip select assignment, keyed write protection
// Notes on behaviour
// R1: remap bit per master enables remapped decoding
// R2: cs1 bit picks static or ddr controller
// R3: cs3 bit activates nand logic on select
// R4: pullup bit zero enables low data pullups
// R5: pulldown bit zero enables low data pulldowns
// R6: drive bit picks low or high drive
// R7: nand lane bit picks lower/upper data bits
// R8: multiport bit enables ddr multiport operation
// R9: software avoids multiport with upper nand lanes
// R10: software puts cs1 on ddr for multiport
// R11: protect enable changes only with correct key
// R12: wrong key ignored; key reads zero
// R13: violation flag sticky until status read
// R14: source field holds offending write offset
// R15: six selects, 26-bit address, 16/32 data
// R16: protected registers refuse writes while protected
// R17: refused write flags violation, keeps contents
// R18: status cleared by reset, writes ignored
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ps
`include "mecw_regs.svh"
module mecw_top #(
    parameter int NUM_MASTERS = 12,
    parameter int NUM_CS      = 6,
    parameter int ADDR_W      = 26,
    parameter int DATA_W      = 32,
    parameter int NAND_W      = 16
) (
    // Clock and reset
    input  wire logic                      clk,
    input  wire logic                      rst,
    // Register port
    input  wire logic [31:0]               reg_addr,
    input  wire logic [31:0]               reg_wdata,
    input  wire logic                      reg_wr,
    input  wire logic                      reg_rd,
    output logic [31:0]                    reg_rdata,
    // Interrupt
    output logic                           irq,
    // Matrix decode controls
    output logic [NUM_MASTERS-1:0]         master_remap_enable,
    // Memory controller side
    input  wire logic [NUM_CS-1:0]         static_memory_ctrl_cs_n,
    input  wire logic [ADDR_W-1:0]         static_memory_ctrl_addr,
    input  wire logic                      ddr_cs_n,
    input  wire logic [NAND_W-1:0]         nand_dout,
    output logic                           ddr_multiport_enable,
    // External bus pin side
    output logic [NUM_CS-1:0]              external_chip_selects_n,
    output logic [ADDR_W-1:0]              ebi_addr,
    output logic                           nand_cs_n,
    output logic [DATA_W-1:0]              nand_lane_dout,
    output mecw_pkg::mecw_pad_t            pad
);
    import mecw_pkg::*;

    // ****************************************************************
    // Decode
    // ****************************************************************
    logic                      sel_remap;
    logic                      sel_csa;
    logic                      sel_wpmode;
    logic                      sel_wpstat;
    logic                      sel_istat;
    logic                      sel_imask;
    logic                      prot_target;
    logic                      wr_ok;
    logic                      wr_refused;
    logic                      key_ok;

    logic [NUM_MASTERS-1:0]    remap_q;
    logic [31:0]               csa_q;
    logic                      protect_enable_q;
    logic                      violation_flag_q;
    logic [15:0]               violation_source_offset_q;
    logic [`MECW_IRQ_W-1:0]    istat_q;
    logic [`MECW_IRQ_W-1:0]    imask_q;
    logic [`MECW_IRQ_W-1:0]    ievent;
    logic [31:0]               rdata_d;
    logic [31:0]               rdata_q;
    mecw_csa_t                 csa;

    always_comb
    begin
        sel_remap  = 1'b0;
        sel_csa    = 1'b0;
        sel_wpmode = 1'b0;
        sel_wpstat = 1'b0;
        sel_istat  = 1'b0;
        sel_imask  = 1'b0;
        if (reg_addr == `MECW_REMAP_ADDR)
            sel_remap = 1'b1;
        else if (reg_addr == `MECW_CSA_ADDR)
            sel_csa = 1'b1;
        else if (reg_addr == `MECW_WPMODE_ADDR)
            sel_wpmode = 1'b1;
        else if (reg_addr == `MECW_WPSTAT_ADDR)
            sel_wpstat = 1'b1;
        else if (reg_addr == `MECW_IRQ_STAT_ADDR)
            sel_istat = 1'b1;
        else if (reg_addr == `MECW_IRQ_MASK_ADDR)
            sel_imask = 1'b1;
    end

    assign prot_target = sel_remap | sel_csa;
    assign wr_refused  = reg_wr & prot_target & protect_enable_q;                     // R16
    assign wr_ok       = reg_wr & prot_target & ~protect_enable_q;                    // R16
    assign key_ok      = reg_wdata[`MECW_WP_KEY_MSB:`MECW_WP_KEY_LSB] == `MECW_WP_PASSWORD;

    // ****************************************************************
    // Configuration registers
    // ****************************************************************
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            remap_q <= '0;
        else if (wr_ok && sel_remap)
            remap_q <= reg_wdata[NUM_MASTERS-1:0];                                    // R1 R17
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            csa_q <= `MECW_CSA_RESET;
        else if (wr_ok && sel_csa)
            csa_q <= reg_wdata;                                                       // R17
    end

    // Key must match in the very same write, otherwise the bit is left alone
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            protect_enable_q <= 1'b0;
        else if (reg_wr && sel_wpmode && key_ok)
            protect_enable_q <= reg_wdata[`MECW_WP_EN_BIT];                           // R11 R12
    end

    // ****************************************************************
    // Violation status
    // ****************************************************************
    // A violation landing in the cycle of the status read survives the read
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            violation_flag_q <= 1'b0;                                                 // R18
        else if (wr_refused)
            violation_flag_q <= 1'b1;                                                 // R13 R17
        else if (reg_rd && sel_wpstat)
            violation_flag_q <= 1'b0;                                                 // R13
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            violation_source_offset_q <= '0;                                          // R18
        else if (wr_refused)
            violation_source_offset_q <= reg_addr[15:0];                              // R14
    end

    // ****************************************************************
    // Interrupts
    // ****************************************************************
    // Misuse event: a write leaves multiport on with upper nand lanes or cs1 off ddr
    always_comb
    begin
        ievent = '0;
        ievent[`MECW_IRQ_VIOL_BIT] = wr_refused;
        ievent[`MECW_IRQ_MISUSE_BIT] = wr_ok && sel_csa && reg_wdata[`MECW_CSA_MP_BIT]
            && (reg_wdata[`MECW_CSA_NAND_BIT] || !reg_wdata[`MECW_CSA_CS1_BIT]);      // R9 R10
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            istat_q <= '0;
        else if (reg_wr && sel_istat)
            istat_q <= (istat_q & ~reg_wdata[`MECW_IRQ_W-1:0]) | ievent;
        else
            istat_q <= istat_q | ievent;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            imask_q <= '0;
        else if (reg_wr && sel_imask)
            imask_q <= reg_wdata[`MECW_IRQ_W-1:0];
    end

    assign irq = |(istat_q & imask_q);

    // ****************************************************************
    // Read data
    // ****************************************************************
    always_comb
    begin
        rdata_d = '0;
        if (sel_remap)
            rdata_d[NUM_MASTERS-1:0] = remap_q;
        else if (sel_csa)
            rdata_d = csa_q;
        else if (sel_wpmode)
            rdata_d[`MECW_WP_EN_BIT] = protect_enable_q;                              // R12
        else if (sel_wpstat)
        begin
            rdata_d[`MECW_WP_EN_BIT] = violation_flag_q;                              // R13
            rdata_d[`MECW_WS_SRC_MSB:`MECW_WS_SRC_LSB] = violation_source_offset_q;   // R14
        end
        else if (sel_istat)
            rdata_d[`MECW_IRQ_W-1:0] = istat_q;
        else if (sel_imask)
            rdata_d[`MECW_IRQ_W-1:0] = imask_q;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            rdata_q <= '0;
        else if (reg_rd)
            rdata_q <= rdata_d;
        else
            rdata_q <= '0;
    end

    assign reg_rdata = rdata_q;

    // ****************************************************************
    // Configuration outputs
    // ****************************************************************
    assign csa.cs1_controller_select    = csa_q[`MECW_CSA_CS1_BIT];
    assign csa.cs3_nand_logic_enable    = csa_q[`MECW_CSA_CS3_BIT];
    assign csa.databus_pullup_disable   = csa_q[`MECW_CSA_PU_BIT];
    assign csa.databus_pulldown_disable = csa_q[`MECW_CSA_PD_BIT];
    assign csa.pad_drive_high           = csa_q[`MECW_CSA_DRIVE_BIT];
    assign csa.nand_upper_lane_select   = csa_q[`MECW_CSA_NAND_BIT];
    assign csa.ddr_multiport_enable     = csa_q[`MECW_CSA_MP_BIT];

    assign master_remap_enable  = remap_q;                                            // R1
    assign ddr_multiport_enable = csa.ddr_multiport_enable;                           // R8

    mecw_route #(
        .NUM_CS (NUM_CS),
        .ADDR_W (ADDR_W),
        .DATA_W (DATA_W),
        .NAND_W (NAND_W)
    ) u_route (
        .clk                     (clk),
        .rst                     (rst),
        .csa                     (csa),
        .static_memory_ctrl_cs_n (static_memory_ctrl_cs_n),
        .static_memory_ctrl_addr (static_memory_ctrl_addr),
        .ddr_cs_n                (ddr_cs_n),
        .nand_dout               (nand_dout),
        .external_chip_selects_n (external_chip_selects_n),
        .ebi_addr                (ebi_addr),
        .nand_cs_n               (nand_cs_n),
        .nand_lane_dout          (nand_lane_dout),
        .pad                     (pad)
    );

    // ****************************************************************
    // Checks
    // ****************************************************************
    chk_remap_write_lands: assert property (@(posedge clk) disable iff (rst)          // R1
        (reg_wr && sel_remap && !protect_enable_q)
        |=> master_remap_enable == $past(reg_wdata[NUM_MASTERS-1:0]))
        else $error("remap write did not land");
    chk_key_gate: assert property (@(posedge clk) disable iff (rst)                   // R11
        (reg_wr && sel_wpmode && key_ok) |=> protect_enable_q == $past(reg_wdata[0]))
        else $error("keyed write did not set protect enable");
    chk_bad_key_hold: assert property (@(posedge clk) disable iff (rst)               // R12
        (reg_wr && sel_wpmode && !key_ok) |=> $stable(protect_enable_q))
        else $error("wrong key changed protect enable");
    chk_key_reads_zero: assert property (@(posedge clk) disable iff (rst)             // R12
        (reg_rd && sel_wpmode) |=> reg_rdata[31:1] == 31'h0)
        else $error("key field not read as zero");
    chk_refused_keeps: assert property (@(posedge clk) disable iff (rst)              // R17
        (reg_wr && sel_csa && protect_enable_q) |=> $stable(csa_q) && violation_flag_q)
        else $error("protected write changed register or missed flag");
    chk_viol_source: assert property (@(posedge clk) disable iff (rst)                // R14
        wr_refused |=> violation_source_offset_q == $past(reg_addr[15:0]))
        else $error("violation source not captured");
    chk_flag_read_clear: assert property (@(posedge clk) disable iff (rst)            // R13
        (reg_rd && sel_wpstat && !wr_refused && violation_flag_q)
        |=> reg_rdata[0] && !violation_flag_q)
        else $error("status read did not report then clear flag");
    chk_status_ro: assert property (@(posedge clk) disable iff (rst)                  // R18
        (reg_wr && sel_wpstat) |=> $stable(violation_source_offset_q) && $stable(violation_flag_q))
        else $error("status write had an effect");
    chk_viol_irq_event: assert property (@(posedge clk) disable iff (rst)             // R17
        wr_refused |=> istat_q[`MECW_IRQ_VIOL_BIT])
        else $error("refused write did not set interrupt status");
    chk_pad_follow: assert property (@(posedge clk) disable iff (rst)                 // R4
        pad.pullup_en[0] == !csa_q[`MECW_CSA_PU_BIT])
        else $error("pullup enable wrong");

    cov_refused_write: cover property (@(posedge clk) disable iff (rst) wr_refused);
    cov_unlock: cover property (@(posedge clk) disable iff (rst)
        protect_enable_q ##1 !protect_enable_q);
    cov_read_clear_race: cover property (@(posedge clk) disable iff (rst)
        wr_refused && reg_rd && sel_wpstat);
    cov_misuse: cover property (@(posedge clk) disable iff (rst) ievent[1]);
endmodule

/* bench/test_matrix_ebi_config_write_protect.sv */
// Self-checking bench for the matrix configuration bank
`timescale 1ns/1ps
`include "mecw_regs.svh"
module test_matrix_ebi_config_write_protect;
    import mecw_pkg::*;

    logic            clk;
    logic            rst;
    logic [31:0]     reg_addr;
    logic [31:0]     reg_wdata;
    logic            reg_wr;
    logic            reg_rd;
    logic [31:0]     reg_rdata;
    logic            irq;
    logic [11:0]     master_remap_enable;
    logic [5:0]      static_memory_ctrl_cs_n;
    logic [25:0]     static_memory_ctrl_addr;
    logic            ddr_cs_n;
    logic [15:0]     nand_dout;
    logic            ddr_multiport_enable;
    logic [5:0]      external_chip_selects_n;
    logic [25:0]     ebi_addr;
    logic            nand_cs_n;
    logic [31:0]     nand_lane_dout;
    mecw_pad_t       pad;
    int              bad_count;
    int              tests_run;
    logic [31:0]     csa_v [4];

    mecw_top i_dut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq), .master_remap_enable(master_remap_enable),
        .static_memory_ctrl_cs_n(static_memory_ctrl_cs_n), .static_memory_ctrl_addr(static_memory_ctrl_addr),
        .ddr_cs_n(ddr_cs_n), .nand_dout(nand_dout), .ddr_multiport_enable(ddr_multiport_enable),
        .external_chip_selects_n(external_chip_selects_n), .ebi_addr(ebi_addr), .nand_cs_n(nand_cs_n),
        .nand_lane_dout(nand_lane_dout), .pad(pad));

    // ****************************************************************
    // Clock and access tasks
    // ****************************************************************
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        tests_run++;
        if (got !== exp)
        begin
            bad_count++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [31:0] a, input logic [31:0] exp, input string msg);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd   <= 1'b0;
        #1;
        chk(reg_rdata, exp, msg);
    endtask

    task automatic summarize();
        $display("Checks %0d, mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial
    begin
        rst = 1'b1; reg_addr = 32'h0; reg_wdata = 32'h0; reg_wr = 1'b0; reg_rd = 1'b0;
        static_memory_ctrl_cs_n = 6'h35; static_memory_ctrl_addr = 26'h2BCDEF1;
        ddr_cs_n = 1'b1; nand_dout = 16'hA5C3; bad_count = 0; tests_run = 0;
        csa_v[0] = 32'h0202030A; csa_v[1] = 32'h01000000; csa_v[2] = 32'h02000000; csa_v[3] = 32'h00000200;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        rd(`MECW_CSA_ADDR, 32'h00000200, "csa reset");
        @(posedge clk);
        #1;
        chk(reg_rdata, 32'h0, "rdata after read cycle");
        chk(pad.pullup_en, 32'h0000FFFF, "reset pullups");
        chk(pad.pulldown_en, 32'h0, "reset pulldowns");
        rd(`MECW_REMAP_ADDR, 32'h0, "remap reset");
        rd(`MECW_WPMODE_ADDR, 32'h0, "protect reset");
        rd(`MECW_WPSTAT_ADDR, 32'h0, "status reset");
        wr(`MECW_REMAP_ADDR, 32'hFFFFFFFF);
        rd(`MECW_REMAP_ADDR, 32'h00000FFF, "remap all");
        wr(`MECW_REMAP_ADDR, 32'h000005A5);
        #1;
        chk({20'h0, master_remap_enable}, 32'h5A5, "remap outputs");
        for (int i = 0; i < 4; i++)
        begin
            wr(`MECW_CSA_ADDR, csa_v[i]);
            rd(`MECW_CSA_ADDR, csa_v[i], "csa readback");
            repeat (2) @(posedge clk);
            #1;
            chk(external_chip_selects_n, csa_v[i][1] ? 6'h37 : 6'h35, "cs1 routing");
            chk(nand_cs_n, csa_v[i][3] ? 1'b0 : 1'b1, "nand select");
            chk(pad.pullup_en, csa_v[i][8] ? 32'h0 : 32'h0000FFFF, "pullups");
            chk(pad.pulldown_en, csa_v[i][9] ? 32'h0 : 32'h0000FFFF, "pulldowns");
            chk(pad.drive_high, csa_v[i][17], "drive");
            chk(nand_lane_dout, csa_v[i][24] ? 32'hA5C30000 : 32'h0000A5C3, "nand lane");
            chk(ddr_multiport_enable, csa_v[i][25], "multiport");
            chk(ebi_addr, 26'h2BCDEF1, "address bus");
        end
        rd(`MECW_IRQ_STAT_ADDR, 32'h2, "misuse event");
        wr(`MECW_IRQ_MASK_ADDR, 32'h2);
        #1;
        chk(irq, 1'b1, "irq raised");
        wr(`MECW_IRQ_STAT_ADDR, 32'h2);
        #1;
        chk(irq, 1'b0, "irq cleared");
        wr(32'hFFFFDF30, 32'hFFFFFFFF);
        rd(32'hFFFFDF30, 32'h0, "unmapped");
        wr(`MECW_WPMODE_ADDR, 32'h4D415501);
        rd(`MECW_WPMODE_ADDR, 32'h0, "wrong key set");
        wr(`MECW_WPMODE_ADDR, {`MECW_WP_PASSWORD, 8'h01});
        rd(`MECW_WPMODE_ADDR, 32'h1, "key set, key reads zero");
        wr(`MECW_IRQ_MASK_ADDR, 32'h1);
        wr(`MECW_CSA_ADDR, 32'h01000000);
        #1;
        chk(irq, 1'b1, "violation irq");
        rd(`MECW_CSA_ADDR, 32'h00000200, "csa kept");
        rd(`MECW_WPSTAT_ADDR, 32'h00DF2001, "violation csa");
        rd(`MECW_WPSTAT_ADDR, 32'h00DF2000, "flag cleared by read");
        wr(`MECW_REMAP_ADDR, 32'h0);
        rd(`MECW_REMAP_ADDR, 32'h5A5, "remap kept");
        rd(`MECW_WPSTAT_ADDR, 32'h00DF0001, "violation remap");
        wr(`MECW_WPSTAT_ADDR, 32'hFFFFFFFF);
        rd(`MECW_WPSTAT_ADDR, 32'h00DF0000, "status write ignored");
        wr(`MECW_IRQ_STAT_ADDR, 32'h1);
        #1;
        chk(irq, 1'b0, "violation irq cleared");
        wr(`MECW_WPMODE_ADDR, 32'h12345600);
        rd(`MECW_WPMODE_ADDR, 32'h1, "wrong key clear");
        wr(`MECW_WPMODE_ADDR, {`MECW_WP_PASSWORD, 8'h00});
        rd(`MECW_WPMODE_ADDR, 32'h0, "key clear");
        wr(`MECW_CSA_ADDR, 32'h01000000);
        rd(`MECW_CSA_ADDR, 32'h01000000, "csa open again");
        rd(`MECW_WPSTAT_ADDR, 32'h00DF0000, "no new violation");
        // Second reset in mid-run must restore the bank
        @(posedge clk);
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        rd(`MECW_WPSTAT_ADDR, 32'h0, "status after reset");
        rd(`MECW_CSA_ADDR, 32'h00000200, "csa after reset");
        summarize();
    end
endmodule
